// [src/tot_pkg.sv]
// turn-on timing package: command codes, word layout, ranges and timing counts
// assumes a 50 MHz clock and a bus protocol engine that delivers whole words
// Behaviour
// RULE1: wait programmed delay after start condition
// RULE2: word is signed exponent 15:11, mantissa
// RULE3: always wait about 100 us initialization
// RULE4: delay accepted 0 to 127.5 ms, 0.5 ms
// RULE5: out-of-range delay or rise write is flagged
// RULE6: reload delay rounded to nearest supported value
// RULE7: ramp reference reaches target exactly at rise end
// RULE8: coarse slope quantization is allowed
// RULE9: rise 0 to 31.75 ms; below 0.5 -> 0.5
// RULE10: rise default from memory or pin strap
// RULE11: bound turn-on time, else timeout fault
// RULE12: timeout runs from delay end to 85 percent
// RULE13: arm undervoltage detection at rise end
// RULE14: timeout limit writes flagged as invalid command
// RULE15: timeout limit 0 to 127 ms, 0.5 ms (code clamps the restored limit but keeps it in 0.25 ms steps)
// RULE16: zero timeout limit disables timeout detection
// RULE17: timeout fault sets sticky flag, reports response
// RULE18: decode mantissa times two to exponent
// RULE19: host uses word reads and writes per code
package tot_pkg;
  localparam int         WORD_W          = 16;
  localparam int         Q_W             = 12;
  localparam int         FRAC_W          = 11;
  localparam int         ACC_W           = 24;
  localparam int         CNT_W           = 24;
  localparam logic [7:0] CMD_DELAY       = 8'h60;
  localparam logic [7:0] CMD_RISE        = 8'h61;
  localparam logic [7:0] CMD_TIMEOUT     = 8'h62;
  localparam int         EXP_MSB         = 15;
  localparam int         EXP_LSB         = 11;
  localparam int         MAN_MSB         = 10;
  localparam logic [4:0] DELAY_EXP_RST   = 5'h1f;
  localparam logic [4:0] RISE_EXP_RST    = 5'h1e;
  localparam logic [4:0] TIMEOUT_EXP_RST = 5'h1f;
  // all limits are in quarter milliseconds
  localparam logic [Q_W-1:0] DELAY_MAX_Q = 12'h1fe;
  localparam logic [Q_W-1:0] RISE_MAX_Q  = 12'h07f;
  localparam logic [Q_W-1:0] RISE_MIN_Q  = 12'h002;
  localparam logic [Q_W-1:0] TMO_MAX_Q   = 12'h1fc;
  localparam logic [FRAC_W-1:0] FRAC_FULL = 11'h400;
  localparam int         CLK_NS          = 20;
  localparam int         QTR_MS_NS       = 250000;
  localparam int         INIT_NS         = 100000;
  localparam int         QTR_MS_CYC      = QTR_MS_NS / CLK_NS;
  localparam int         INIT_CYC        = (INIT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {ST_IDLE, ST_INIT, ST_DELAY, ST_RISE, ST_ON} tot_state_e;
endpackage : tot_pkg

// [src/tot_slin_dec.sv]
// linear-format word decoder to quarter milliseconds
// assumes a caller that range-checks the result
`timescale 1ns/10ps
module tot_slin_dec (
  // word in
  input  wire logic [tot_pkg::WORD_W-1:0] word,
  // value in quarter milliseconds
  output logic      [tot_pkg::Q_W-1:0]    q,
  output logic      [tot_pkg::Q_W-1:0]    q_near,
  output logic                            exact,
  output logic                            bad
);
  import tot_pkg::*;
  logic signed [31:0] man_w;
  logic signed [31:0] val_w;
  logic signed [31:0] near_w;
  logic signed [6:0]  sh;

  // quarter units: mantissa times two to the exponent plus two [RULE18] [RULE2]
  assign man_w = {{21{word[MAN_MSB]}}, word[MAN_MSB:0]};
  assign sh    = {{2{word[EXP_MSB]}}, word[EXP_MSB:EXP_LSB]} + 7'sd2;

  always_comb begin
    if (!sh[6]) begin
      val_w  = man_w <<< sh;
      near_w = val_w;
      exact  = 1'b1;
    end else begin
      val_w  = man_w >>> (-sh);
      near_w = (man_w + (32'sd1 <<< (-sh - 7'sd1))) >>> (-sh);
      exact  = (val_w <<< (-sh)) == man_w;
    end
    bad    = (man_w < 0) || (val_w > 32'sd4095);
    q      = val_w[Q_W-1:0];
    q_near = (near_w > 32'sd4095) ? 12'hfff : near_w[Q_W-1:0];
  end
endmodule : tot_slin_dec

// [src/tot_qms_timer.sv]
// quarter-millisecond down timer with restartable prescaler
// done is combinational and marks the last cycle of the interval
`timescale 1ns/10ps
module tot_qms_timer #(
  parameter int QTR_CYCLES = tot_pkg::QTR_MS_CYC
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // control
  input  wire logic                    start,
  input  wire logic                    abort,
  input  wire logic [tot_pkg::Q_W-1:0] load_q,
  // status
  output logic                         busy,
  output logic                         done
);
  import tot_pkg::*;
  logic             busy_r;
  logic [CNT_W-1:0] cyc_r;
  logic [Q_W-1:0]   qn_r;
  logic             wrap;

  assign wrap = busy_r && (cyc_r == CNT_W'(QTR_CYCLES - 1));
  assign busy = busy_r;
  assign done = !abort && ((start && load_q == '0) || (!start && wrap && qn_r == 12'h001));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cyc_r  <= '0;
      qn_r   <= '0;
    end else if (abort) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= load_q != '0;
      cyc_r  <= '0;
      qn_r   <= load_q;
    end else if (wrap) begin
      cyc_r <= '0;
      qn_r  <= qn_r - 12'h001;
      if (qn_r == 12'h001) begin
        busy_r <= 1'b0;
      end
    end else if (busy_r) begin
      cyc_r <= cyc_r + CNT_W'(1);
    end
  end
endmodule : tot_qms_timer

// [src/tot_turn_on_timing.sv]
// turn-on timing settings, start-up sequencer, rise ramp and timeout watch
// assumes a protocol engine giving word commands and same-clock status inputs
`timescale 1ns/10ps
module tot_turn_on_timing #(
  parameter int QTR_CYCLES  = tot_pkg::QTR_MS_CYC,
  parameter int INIT_CYCLES = tot_pkg::INIT_CYC
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  // word command port
  input  wire logic                       cmd_wr,
  input  wire logic                       cmd_rd,
  input  wire logic [7:0]                 cmd_code,
  input  wire logic [tot_pkg::WORD_W-1:0] cmd_wdata,
  output logic      [tot_pkg::WORD_W-1:0] rd_data,
  output logic                            rd_valid,
  // nonvolatile restore and strap
  input  wire logic                       nvm_load,
  input  wire logic [tot_pkg::WORD_W-1:0] nvm_delay,
  input  wire logic [tot_pkg::WORD_W-1:0] nvm_rise,
  input  wire logic [tot_pkg::WORD_W-1:0] nvm_timeout,
  input  wire logic                       strap_rise_valid,
  input  wire logic [tot_pkg::WORD_W-1:0] strap_rise,
  // sequencing
  input  wire logic                       start_cond,
  input  wire logic                       vout_at_85,
  input  wire logic                       clear_faults,
  output logic                            ramp_active,
  output logic      [tot_pkg::FRAC_W-1:0] ramp_frac,
  output logic                            uv_arm,
  // status
  output logic                            ton_max_fault,
  output logic                            ton_max_flag,
  output logic                            data_err_flag,
  output logic                            cmd_err_flag,
  output logic                            alert_n
);
  import tot_pkg::*;

  logic [WORD_W-1:0] dec_in    [4];
  logic [Q_W-1:0]    dec_q     [4];
  logic [Q_W-1:0]    dec_near  [4];
  logic              dec_exact [4];
  logic              dec_bad   [4];

  logic [WORD_W-1:0] delay_r;
  logic [WORD_W-1:0] rise_r;
  logic [WORD_W-1:0] tmo_r;
  logic [Q_W-1:0]    delay_q_r;
  logic [Q_W-1:0]    rise_q_r;
  logic [Q_W-1:0]    tmo_q_r;
  logic [WORD_W-1:0] rd_data_r;
  logic              rd_valid_r;

  logic              wr_delay;
  logic              wr_rise;
  logic              wr_tmo;
  logic              delay_ok;
  logic              rise_ok;
  logic              data_err;
  logic [Q_W-1:0]    nvm_dly_c;
  logic [Q_W-1:0]    nvm_dly_h;

  tot_state_e        st_r;
  logic [CNT_W-1:0]  init_cnt_r;
  logic              init_end;
  logic              abort;
  logic              dly_start;
  logic              dly_done;
  logic              rise_done;
  logic              tmo_start;
  logic              tmo_done;
  logic [ACC_W-1:0]  rise_total_r;
  logic [ACC_W-1:0]  acc_r;
  logic [ACC_W-1:0]  acc_sum;
  logic [FRAC_W-1:0] ramp_frac_r;
  logic              uv_arm_r;
  logic              ton_fault_r;
  logic              ton_max_r;
  logic              data_err_r;
  logic              cmd_err_r;
  logic              ton_max_nxt;
  logic              data_err_nxt;
  logic              cmd_err_nxt;
  logic              alert_n_r;

  function automatic logic fits(input logic [Q_W-1:0] q, input logic exact,
                                input logic bad, input logic [Q_W-1:0] max_q,
                                input logic half_only);
    return !bad && exact && (q <= max_q) && !(half_only && q[0]);
  endfunction : fits

  function automatic logic [Q_W-1:0] clamp_q(input logic [Q_W-1:0] q,
                                             input logic [Q_W-1:0] lo,
                                             input logic [Q_W-1:0] hi);
    return (q < lo) ? lo : ((q > hi) ? hi : q);
  endfunction : clamp_q

  // decoders: write data, restored delay, restored rise, restored limit
  assign dec_in[0] = cmd_wdata;
  // restored delay decoded one exponent lower, giving half milliseconds directly
  assign dec_in[1] = {nvm_delay[EXP_MSB:EXP_LSB] - 5'h01, nvm_delay[MAN_MSB:0]};
  assign dec_in[2] = strap_rise_valid ? strap_rise : nvm_rise;  // [RULE10]
  assign dec_in[3] = nvm_timeout;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_dec
      tot_slin_dec u_dec (
        .word   (dec_in[i]),
        .q      (dec_q[i]),
        .q_near (dec_near[i]),
        .exact  (dec_exact[i]),
        .bad    (dec_bad[i])
      );
    end
  endgenerate

  // write checks
  assign wr_delay = cmd_wr && (cmd_code == CMD_DELAY);
  assign wr_rise  = cmd_wr && (cmd_code == CMD_RISE);
  assign wr_tmo   = cmd_wr && (cmd_code == CMD_TIMEOUT);
  assign delay_ok = fits(dec_q[0], dec_exact[0], dec_bad[0], DELAY_MAX_Q, 1'b1);  // [RULE4]
  assign rise_ok  = fits(dec_q[0], dec_exact[0], dec_bad[0], RISE_MAX_Q, 1'b0);   // [RULE9]
  assign data_err = (wr_delay && !delay_ok) || (wr_rise && !rise_ok);            // [RULE5]

  // restored delay rounded once to the nearest half millisecond, then back to quarters;
  // rounding to quarters first and then to halves could land one step off
  assign nvm_dly_c = dec_bad[1] ? '0 : clamp_q(dec_near[1], '0, {1'b0, DELAY_MAX_Q[Q_W-1:1]});  // [RULE6]
  assign nvm_dly_h = {nvm_dly_c[Q_W-2:0], 1'b0};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      delay_r   <= {DELAY_EXP_RST, 11'h000};  // [RULE2]
      rise_r    <= {RISE_EXP_RST, 11'h000};
      tmo_r     <= {TIMEOUT_EXP_RST, 11'h000};
      delay_q_r <= '0;
      rise_q_r  <= RISE_MIN_Q;
      tmo_q_r   <= '0;
    end else if (nvm_load) begin
      delay_r   <= {DELAY_EXP_RST, nvm_dly_h[Q_W-1:1]};  // [RULE6]
      delay_q_r <= nvm_dly_h;
      rise_r    <= dec_in[2];
      rise_q_r  <= clamp_q(dec_bad[2] ? '0 : dec_near[2], RISE_MIN_Q, RISE_MAX_Q);
      tmo_r     <= nvm_timeout;
      tmo_q_r   <= clamp_q(dec_bad[3] ? '0 : dec_near[3], '0, TMO_MAX_Q);  // [RULE15]
    end else if (wr_delay && delay_ok) begin
      delay_r   <= cmd_wdata;
      delay_q_r <= dec_q[0];
    end else if (wr_rise && rise_ok) begin
      rise_r    <= cmd_wdata;
      rise_q_r  <= clamp_q(dec_q[0], RISE_MIN_Q, RISE_MAX_Q);  // [RULE9]
    end
  end

  // word reads [RULE19]
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= cmd_rd;
      if (cmd_rd) begin
        unique case (cmd_code)
          CMD_DELAY:   rd_data_r <= delay_r;
          CMD_RISE:    rd_data_r <= rise_r;
          CMD_TIMEOUT: rd_data_r <= tmo_r;
          default:     rd_data_r <= '0;
        endcase
      end
    end
  end

  // start-up sequencer
  assign abort     = !start_cond;
  assign init_end  = (st_r == ST_INIT) && (init_cnt_r == CNT_W'(INIT_CYCLES - 1));
  assign dly_start = init_end && !abort;
  assign tmo_start = dly_done && (tmo_q_r != '0);  // [RULE16]

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r       <= ST_IDLE;
      init_cnt_r <= '0;
    end else if (abort) begin
      st_r <= ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          st_r       <= ST_INIT;
          init_cnt_r <= '0;
        end
        ST_INIT: begin
          init_cnt_r <= init_cnt_r + CNT_W'(1);  // [RULE3]
          if (dly_done) begin
            st_r <= ST_RISE;
          end else if (init_end) begin
            st_r <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (dly_done) begin
            st_r <= ST_RISE;  // [RULE1]
          end
        end
        ST_RISE: begin
          if (rise_done) begin
            st_r <= ST_ON;
          end
        end
        ST_ON: st_r <= ST_ON;
      endcase
    end
  end

  tot_qms_timer #(.QTR_CYCLES(QTR_CYCLES)) u_dly (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (dly_start),
    .abort  (abort),
    .load_q (delay_q_r),
    .busy   (),
    .done   (dly_done)
  );

  tot_qms_timer #(.QTR_CYCLES(QTR_CYCLES)) u_rise (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (dly_done),
    .abort  (abort),
    .load_q (rise_q_r),
    .busy   (),
    .done   (rise_done)
  );

  // timeout window closes when the output reaches 85 percent [RULE12]
  tot_qms_timer #(.QTR_CYCLES(QTR_CYCLES)) u_tmo (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (tmo_start),
    .abort  (abort || vout_at_85),
    .load_q (tmo_q_r),
    .busy   (),
    .done   (tmo_done)
  );

  // reference ramp as a fraction of target, full scale at rise end [RULE7]
  // one step per cycle at most; slope quantization is accepted [RULE8]
  assign acc_sum = acc_r + ACC_W'(FRAC_FULL);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rise_total_r <= '0;
      acc_r        <= '0;
      ramp_frac_r  <= '0;
    end else if (abort) begin
      acc_r       <= '0;
      ramp_frac_r <= '0;
    end else if (dly_done) begin
      rise_total_r <= ACC_W'(32'(rise_q_r) * 32'(QTR_CYCLES));
      acc_r        <= '0;
      ramp_frac_r  <= '0;
    end else if (st_r == ST_RISE) begin
      if (acc_sum >= rise_total_r) begin
        acc_r       <= acc_sum - rise_total_r;
        ramp_frac_r <= ramp_frac_r + FRAC_W'(1);
      end else begin
        acc_r <= acc_sum;
      end
    end
  end

  // undervoltage detection armed once the rise is over [RULE13]
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      uv_arm_r <= 1'b0;
    end else if (abort) begin
      uv_arm_r <= 1'b0;
    end else if (rise_done) begin
      uv_arm_r <= 1'b1;
    end
  end

  // sticky status, a new event wins over a clear in the same cycle
  assign ton_max_nxt  = (tmo_done && !vout_at_85) || (ton_max_r && !clear_faults);  // [RULE17]
  assign data_err_nxt = data_err || (data_err_r && !clear_faults);                  // [RULE5]
  assign cmd_err_nxt  = wr_tmo || (cmd_err_r && !clear_faults);                     // [RULE14]

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ton_fault_r <= 1'b0;
      ton_max_r   <= 1'b0;
      data_err_r  <= 1'b0;
      cmd_err_r   <= 1'b0;
      alert_n_r   <= 1'b1;
    end else begin
      ton_fault_r <= tmo_done && !vout_at_85;  // [RULE11]
      ton_max_r   <= ton_max_nxt;
      data_err_r  <= data_err_nxt;
      cmd_err_r   <= cmd_err_nxt;
      alert_n_r   <= !(ton_max_nxt || data_err_nxt || cmd_err_nxt);
    end
  end

  assign rd_data       = rd_data_r;
  assign rd_valid      = rd_valid_r;
  assign ramp_active   = st_r == ST_RISE;
  assign ramp_frac     = ramp_frac_r;
  assign uv_arm        = uv_arm_r;
  assign ton_max_fault = ton_fault_r;
  assign ton_max_flag  = ton_max_r;
  assign data_err_flag = data_err_r;
  assign cmd_err_flag  = cmd_err_r;
  assign alert_n       = alert_n_r;

  property p_init_len;
    @(posedge clock) disable iff (!rst_n)
      (st_r == ST_INIT) && !abort && ($past(st_r) == ST_IDLE) |-> !ramp_active [*8];
  endproperty
  a_init_len: assert property (p_init_len) else $error("ramp began during init");  // [RULE3]

  property p_delay_range;
    @(posedge clock) disable iff (!rst_n)
      wr_delay && !nvm_load && (dec_q[0] > DELAY_MAX_Q) |=> data_err_r && $stable(delay_r);
  endproperty
  a_delay_range: assert property (p_delay_range) else $error("bad delay kept");  // [RULE4]

  property p_rise_min;
    @(posedge clock) disable iff (!rst_n)
      $rose(ramp_active) |-> (rise_total_r >= ACC_W'(2 * QTR_CYCLES));
  endproperty
  a_rise_min: assert property (p_rise_min) else $error("rise shorter than min");  // [RULE9]

  property p_tmo_write;
    @(posedge clock) disable iff (!rst_n)
      wr_tmo && !nvm_load |=> cmd_err_r && !alert_n && $stable(tmo_r);
  endproperty
  a_tmo_write: assert property (p_tmo_write) else $error("limit write accepted");  // [RULE14]

  property p_tmo_off;
    @(posedge clock) disable iff (!rst_n)
      (tmo_q_r == '0) && $stable(tmo_q_r) |=> !ton_max_fault;
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("fault with zero limit");  // [RULE16]

  property p_uv_arm;
    @(posedge clock) disable iff (!rst_n)
      (st_r == ST_RISE) && !abort ##1 !uv_arm |-> !$past(rise_done);
  endproperty
  a_uv_arm: assert property (p_uv_arm) else $error("uv arm late");  // [RULE13]

  property p_ramp_full;
    @(posedge clock) disable iff (!rst_n)
      rise_done && !abort |=> (ramp_frac == FRAC_FULL) && uv_arm && !ramp_active;
  endproperty
  a_ramp_full: assert property (p_ramp_full) else $error("ramp not full at end");  // [RULE7]

  property p_fault_flag;
    @(posedge clock) disable iff (!rst_n)
      ton_max_fault |-> ton_max_flag ##1 (ton_max_flag || $past(clear_faults));
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("timeout flag missing");  // [RULE17]

  property p_nvm_near;
    @(posedge clock) disable iff (!rst_n)
      nvm_load |=> !delay_q_r[0] && (delay_q_r <= DELAY_MAX_Q) && (delay_r[4:0] == delay_q_r[5:1]);
  endproperty
  a_nvm_near: assert property (p_nvm_near) else $error("restored delay unsupported");  // [RULE6]
endmodule : tot_turn_on_timing

// [testbench/tot_host_model.sv]
// host-side model issuing word writes and word reads on the command port
// assumes the bench calls its tasks; strobes change only at falling edges
`timescale 1ns/10ps
module tot_host_model (
  // clock
  input  wire logic                       clock,
  // command port
  output logic                            cmd_wr,
  output logic                            cmd_rd,
  output logic      [7:0]                 cmd_code,
  output logic      [tot_pkg::WORD_W-1:0] cmd_wdata,
  input  wire logic [tot_pkg::WORD_W-1:0] rd_data,
  input  wire logic                       rd_valid
);
  import tot_pkg::*;

  initial begin
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_code  = 8'h5a;
    cmd_wdata = 16'ha5c3;
  end

  // one write word; idle lines then carry the inverse so stale data is never trusted
  task automatic wr_word(input logic [7:0] code, input logic [WORD_W-1:0] data);
    @(negedge clock);
    cmd_code  = code;
    cmd_wdata = data;
    cmd_wr    = 1'b1;
    @(negedge clock);
    cmd_wr    = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~data;
  endtask : wr_word

  // one read word; the answer is taken in the cycle it stands
  task automatic rd_word(input logic [7:0] code, output logic [WORD_W-1:0] data,
                         output logic ok);
    @(negedge clock);
    cmd_code = code;
    cmd_rd   = 1'b1;
    @(negedge clock);
    cmd_rd   = 1'b0;
    cmd_code = ~code;
    ok       = rd_valid;
    data     = rd_data;
  endtask : rd_word
endmodule : tot_host_model

// [testbench/tb.sv]
// self-checking bench: turn-on timing words, start-up sequence and timeout watch
// assumes the host model drives the command port; timers run shortened
`timescale 1ns/10ps
module tb;
  import tot_pkg::*;
  localparam int QC = 600;
  localparam int IC = 20;
  logic              clock, rst_n, cmd_wr, cmd_rd, rd_valid, nvm_load, strap_rise_valid;
  logic              start_cond, vout_at_85, clear_faults, ramp_active, uv_arm;
  logic              ton_max_fault, ton_max_flag, data_err_flag, cmd_err_flag, alert_n;
  logic [7:0]        cmd_code;
  logic [WORD_W-1:0] cmd_wdata, rd_data, nvm_delay, nvm_rise, nvm_timeout, strap_rise;
  logic [WORD_W-1:0] m_delay, m_rise;
  logic [FRAC_W-1:0] ramp_frac;
  logic [23:0]       tbl[$];
  int                failures, tests_run, seed;

  tot_turn_on_timing #(.QTR_CYCLES(QC), .INIT_CYCLES(IC)) uut (
    .clock(clock), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .nvm_load(nvm_load),
    .nvm_delay(nvm_delay), .nvm_rise(nvm_rise), .nvm_timeout(nvm_timeout),
    .strap_rise_valid(strap_rise_valid), .strap_rise(strap_rise), .start_cond(start_cond),
    .vout_at_85(vout_at_85), .clear_faults(clear_faults), .ramp_active(ramp_active),
    .ramp_frac(ramp_frac), .uv_arm(uv_arm), .ton_max_fault(ton_max_fault),
    .ton_max_flag(ton_max_flag), .data_err_flag(data_err_flag),
    .cmd_err_flag(cmd_err_flag), .alert_n(alert_n));

  tot_host_model host (
    .clock(clock), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  always #10 clock = ~clock;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp, input int tol, input string what);
    tests_run++;
    if (got < exp - tol || got > exp + tol) begin
      failures++;
      $display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : chk_n

  // value in quarter milliseconds, negative when inexact or below zero
  function automatic int dec_q(input logic [15:0] w);
    int m;
    int e;
    m = int'($signed(w[10:0]));
    e = int'($signed(w[15:11])) + 2;
    if (e >= 0) return m * (1 << e);
    if (m % (1 << -e) != 0) return -1;
    return m / (1 << -e);
  endfunction : dec_q

  function automatic logic [15:0] exp_reg(input logic [7:0] code);
    if (code == CMD_DELAY) return m_delay;
    if (code == CMD_RISE) return m_rise;
    if (code == CMD_TIMEOUT) return 16'hf800;
    return 16'h0000;
  endfunction : exp_reg

  task automatic clr;
    clear_faults = 1'b1;
    @(negedge clock);
    clear_faults = 1'b0;
    @(negedge clock);
    chk({ton_max_flag, data_err_flag, cmd_err_flag, alert_n}, 16'h1, "clear");
  endtask : clr

  task automatic host_wr(input logic [7:0] code, input logic [15:0] w);
    int   q;
    logic de;
    q  = dec_q(w);
    de = 1'b0;
    if (code == CMD_DELAY) begin
      if (q >= 0 && q <= 510 && q % 2 == 0) m_delay = w;
      else de = 1'b1;
    end
    if (code == CMD_RISE) begin
      if (q >= 0 && q <= 127) m_rise = w;
      else de = 1'b1;
    end
    host.wr_word(code, w);
    chk(data_err_flag, de, "data flag");
    chk(cmd_err_flag, code == CMD_TIMEOUT, "cmd flag");
    chk(alert_n, !(de || code == CMD_TIMEOUT), "alert");
    clr();
  endtask : host_wr

  task automatic host_rd(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host.rd_word(code, d, ok);
    chk(ok, 1'b1, "rd_valid");
    chk(d, exp, "read word");
  endtask : host_rd

  task automatic nvm(input logic [15:0] d, r, t, s, input logic sv);
    @(negedge clock);
    {nvm_delay, nvm_rise, nvm_timeout, strap_rise, strap_rise_valid} = {d, r, t, s, sv};
    nvm_load = 1'b1;
    @(negedge clock);
    nvm_load = 1'b0;
  endtask : nvm

  // one start-up: delay, rise, then watch for the timeout pulse
  task automatic run_seq(input int dq, input int rq, input int tq, input logic v85);
    int n;
    int r;
    int f;
    n = 0;
    r = 0;
    f = -100;
    @(negedge clock);
    start_cond = 1'b1;
    while (ramp_active !== 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    chk_n(n, IC + dq * QC, 3, "start to rise");
    if (n >= 20000) report_and_stop();
    vout_at_85 = v85;
    while (ramp_active === 1'b1 && r < 30000) begin
      if (ton_max_fault === 1'b1 && f < 0) f = r;
      @(negedge clock);
      r++;
    end
    chk_n(r, rq * QC, 0, "rise length");
    if (r >= 30000) report_and_stop();
    chk(ramp_frac, 16'h400, "ramp end");
    chk(uv_arm, 1'b1, "uv armed");
    repeat (tq * QC + 8) begin
      if (ton_max_fault === 1'b1 && f < 0) f = r;
      @(negedge clock);
      r++;
    end
    chk_n(f, (tq != 0 && !v85) ? tq * QC : -100, 3, "timeout");
    chk({ton_max_flag, alert_n}, {14'h0, f >= 0, f < 0}, "tmo flag");
    start_cond = 1'b0;
    vout_at_85 = 1'b0;
    @(negedge clock);
    chk({ramp_active, uv_arm}, 16'h0, "abort");
    clr();
  endtask : run_seq

  initial begin
    seed = 32'hf6b7684a;
    failures = 0;
    tests_run = 0;
    clock = 1'b0;
    rst_n = 1'b0;
    {nvm_load, strap_rise_valid, start_cond, vout_at_85, clear_faults} = 5'h0;
    {nvm_delay, nvm_rise, nvm_timeout, strap_rise} = {4{16'h0000}};
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    m_delay = 16'hf800;
    m_rise = 16'hf000;
    host_rd(CMD_DELAY, 16'hf800);
    host_rd(CMD_RISE, 16'hf000);
    host_rd(CMD_TIMEOUT, 16'hf800);
    run_seq(0, 2, 0, 1'b0);
    // boundaries, sign, inexact steps, timeout and unknown codes, then random words
    tbl = {24'h60f900, 24'h60f9ff, 24'h60ffff, 24'h60f001, 24'h60f002, 24'h600801,
           24'h61f07f, 24'h61f080, 24'h61e801, 24'h61e802, 24'h61f7ff, 24'h62f804,
           24'h631234};
    repeat (8) tbl.push_back({($random(seed) & 1) ? 8'h61 : 8'h60, 3'b111, 13'($random(seed))});
    foreach (tbl[i]) begin
      host_wr(tbl[i][23:16], tbl[i][15:0]);
      host_rd(tbl[i][23:16], exp_reg(tbl[i][23:16]));
    end
    host_wr(CMD_DELAY, 16'hf804);
    host_wr(CMD_RISE, 16'hf001);
    run_seq(8, 2, 0, 1'b0);
    nvm(16'he819, 16'hf010, 16'hf802, 16'hf008, 1'b1);
    host_rd(CMD_DELAY, 16'hf806);
    run_seq(12, 8, 4, 1'b0);
    run_seq(12, 8, 4, 1'b1);
    nvm(16'hf800, 16'hf004, 16'hf800, 16'hf008, 1'b0);
    run_seq(0, 4, 0, 1'b0);
    report_and_stop();
  end
endmodule : tb
